// File: shared/apcc_map.svh
// Constants for the converter power and setup-word control block
`ifndef APCC_MAP_SVH
`define APCC_MAP_SVH

// ****************************************
// Serial word layout
// ****************************************
`define APCC_WORD_BITS 16
`define APCC_SETUP_HI 15
`define APCC_SETUP_LO 11
`define APCC_CFG_SETUP_CODE 5'h10
`define APCC_CFG_RESET 11'h000

// ****************************************
// Setup word field positions
// ****************************************
`define APCC_REFERENCE_SOURCE_SELECT_BIT 10
`define APCC_AVERAGING_ENABLE_BIT 9
`define APCC_AVERAGING_COUNT_HI 8
`define APCC_AVERAGING_COUNT_LO 7
`define APCC_REPEAT_RESULT_COUNT_HI 6
`define APCC_REPEAT_RESULT_COUNT_LO 5
`define APCC_SPM_HI 4
`define APCC_SPM_LO 3

// ****************************************
// Mode codes
// ****************************************
`define APCC_SPM_FULL 2'h1
`define APCC_SPM_PARTIAL 2'h2
`define APCC_PM_AUTO_OFF 2'h1
`define APCC_PM_STANDBY 2'h2

// ****************************************
// Timing
// ****************************************
`define APCC_WAKE_DISCARD 2'h2

`endif

// File: shared/apcc_pkg.sv
// Types for the converter power and setup-word control block
package apcc_pkg;
  typedef enum logic {
    PS_ON,
    PS_DOWN
  } apcc_power_state_t;
  typedef logic [10:0] apcc_cfg_t;
  typedef logic [15:0] apcc_word_t;
endpackage

// File: shared/apcc_word_if.sv
// Carrier for received serial words and frame edges
`timescale 1ns/1ns
`default_nettype none
interface apcc_word_if;
  apcc_pkg::apcc_word_t word;
  logic word_valid;
  logic frame_start;
  logic frame_end;
  modport rx (
    output word,
    output word_valid,
    output frame_start,
    output frame_end
  );
  modport ctl (
    input word,
    input word_valid,
    input frame_start,
    input frame_end
  );
endinterface
`default_nettype wire

// File: design/apcc_serial_rx.sv
// Three-wire serial word receiver framed by chip select
`timescale 1ns/1ns
`default_nettype none
`include "apcc_map.svh"
module apcc_serial_rx (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic chip_select_n_in,
  input wire logic serial_clock_in,
  input wire logic serial_data_in,
  apcc_word_if.rx link
);
  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic cs_meta_reg;
  logic cs_sync_reg;
  logic cs_prev_reg;
  logic sclk_meta_reg;
  logic sclk_sync_reg;
  logic sclk_prev_reg;
  logic din_meta_reg;
  logic din_sync_reg;

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      cs_meta_reg <= 1'b1;
      cs_sync_reg <= 1'b1;
      cs_prev_reg <= 1'b1;
      sclk_meta_reg <= 1'b0;
      sclk_sync_reg <= 1'b0;
      sclk_prev_reg <= 1'b0;
      din_meta_reg <= 1'b0;
      din_sync_reg <= 1'b0;
    end else begin
      cs_meta_reg <= chip_select_n_in;
      cs_sync_reg <= cs_meta_reg;
      cs_prev_reg <= cs_sync_reg;
      sclk_meta_reg <= serial_clock_in;
      sclk_sync_reg <= sclk_meta_reg;
      sclk_prev_reg <= sclk_sync_reg;
      din_meta_reg <= serial_data_in;
      din_sync_reg <= din_meta_reg;
    end
  end

  // ****************************************
  // Shift and frame edges
  // ****************************************
  logic sclk_rise;
  logic cs_fall;
  logic cs_rise;
  logic [4:0] count_reg;
  apcc_pkg::apcc_word_t shift_reg;

  assign sclk_rise = sclk_sync_reg && !sclk_prev_reg;
  assign cs_fall = !cs_sync_reg && cs_prev_reg;
  assign cs_rise = cs_sync_reg && !cs_prev_reg;

  // Extra clocks keep the last sixteen bits; a short frame yields no word
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      shift_reg <= 16'h0000;
      count_reg <= 5'h00;
    end else if (cs_fall) begin
      count_reg <= 5'h00;
    end else if (!cs_sync_reg && sclk_rise) begin
      shift_reg <= {shift_reg[14:0], din_sync_reg};
      if (count_reg != 5'(`APCC_WORD_BITS)) begin
        count_reg <= count_reg + 5'h01;
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      link.word <= 16'h0000;
      link.word_valid <= 1'b0;
      link.frame_start <= 1'b0;
      link.frame_end <= 1'b0;
    end else begin
      link.word <= shift_reg;
      link.word_valid <= cs_rise && (count_reg == 5'(`APCC_WORD_BITS));
      link.frame_start <= cs_fall;
      link.frame_end <= cs_rise;
    end
  end
endmodule
`default_nettype wire

// File: design/apcc_top.sv
// Power management and setup-word register of the converter
`timescale 1ns/1ns
`default_nettype none
`include "apcc_map.svh"
module apcc_top (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic chip_select_n_in,
  input wire logic serial_clock_in,
  input wire logic serial_data_in,
  input wire logic convert_start_pin_n_in,
  input wire logic internal_clock_mode_in,
  input wire logic repeat_mode_in,
  input wire logic [1:0] auto_power_mode_in,
  input wire logic software_convert_bit_in,
  input wire logic conversion_done_in,
  output logic core_power_on_out,
  output logic bias_power_on_out,
  output logic reference_power_on_out,
  output logic conversion_valid_out,
  output logic reference_differential_out,
  output logic averaging_active_out,
  output logic [5:0] conversions_per_result_out,
  output logic [4:0] repeat_result_count_out,
  output logic [10:0] setup_word_out
);
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [5:0] avg_conversions(input logic avg_on, input logic [1:0] code);
    logic [5:0] n;
    n = 6'h01;
    if (avg_on) begin
      n = 6'(6'h04 << code);
    end
    return n;
  endfunction

  function automatic logic [4:0] repeat_results(input logic [1:0] code);
    return 5'({3'h0, code} + 5'h01) << 2;
  endfunction

  // ****************************************
  // Serial receiver
  // ****************************************
  apcc_word_if word_bus ();

  apcc_serial_rx u_rx (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .chip_select_n_in(chip_select_n_in),
    .serial_clock_in(serial_clock_in),
    .serial_data_in(serial_data_in),
    .link(word_bus.rx)
  );

  // ****************************************
  // Setup register
  // ****************************************
  apcc_pkg::apcc_cfg_t cfg_reg;
  logic cfg_hit;

  assign cfg_hit = word_bus.word[`APCC_SETUP_HI:`APCC_SETUP_LO] == `APCC_CFG_SETUP_CODE;

  // Only reset and a matching word touch it; power state never does
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      cfg_reg <= `APCC_CFG_RESET;
    end else if (word_bus.word_valid && cfg_hit) begin
      cfg_reg <= word_bus.word[10:0];
    end
  end

  logic [1:0] static_mode;
  logic static_full;
  logic static_partial;
  logic avg_on;

  assign static_mode = cfg_reg[`APCC_SPM_HI:`APCC_SPM_LO];
  assign static_full = static_mode == `APCC_SPM_FULL;
  assign static_partial = static_mode == `APCC_SPM_PARTIAL;
  assign avg_on = cfg_reg[`APCC_AVERAGING_ENABLE_BIT] && internal_clock_mode_in;

  // ****************************************
  // Convert start pin synchroniser
  // ****************************************
  logic cnv_meta_reg;
  logic cnv_sync_reg;
  logic cnv_prev_reg;
  logic cnv_fall;

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      cnv_meta_reg <= 1'b1;
      cnv_sync_reg <= 1'b1;
      cnv_prev_reg <= 1'b1;
    end else begin
      cnv_meta_reg <= convert_start_pin_n_in;
      cnv_sync_reg <= cnv_meta_reg;
      cnv_prev_reg <= cnv_sync_reg;
    end
  end

  assign cnv_fall = !cnv_sync_reg && cnv_prev_reg;

  // ****************************************
  // Automatic power sequencing
  // ****************************************
  apcc_pkg::apcc_power_state_t state_reg;
  apcc_pkg::apcc_power_state_t state_next;
  logic auto_mode;
  logic ext_auto;
  logic int_auto;
  logic arm_reg;
  logic wake;
  logic sleep;

  // Code 11 is unused and behaves as normal
  assign auto_mode = (auto_power_mode_in == `APCC_PM_AUTO_OFF) ||
                     (auto_power_mode_in == `APCC_PM_STANDBY);
  assign ext_auto = auto_mode && !internal_clock_mode_in;
  assign int_auto = auto_mode && internal_clock_mode_in;

  // The first frame to end in this mode arms; the one after it powers down
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      arm_reg <= 1'b0;
    end else if (!ext_auto) begin
      arm_reg <= 1'b0;
    end else if (word_bus.frame_end) begin
      arm_reg <= 1'b1;
    end
  end

  always_comb begin
    sleep = 1'b0;
    wake = 1'b0;
    if (ext_auto) begin
      sleep = word_bus.frame_end && arm_reg;
      wake = word_bus.frame_start;
    end else if (int_auto) begin
      sleep = conversion_done_in;
      wake = cnv_fall || (word_bus.frame_end && software_convert_bit_in);
    end else begin
      wake = 1'b1;
    end
  end

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      apcc_pkg::PS_ON: begin
        if (sleep) begin
          state_next = apcc_pkg::PS_DOWN;
        end
      end
      apcc_pkg::PS_DOWN: begin
        if (wake) begin
          state_next = apcc_pkg::PS_ON;
        end
      end
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      state_reg <= apcc_pkg::PS_ON;
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************
  // Wake discard counter
  // ****************************************
  logic [1:0] discard_reg;
  logic conv_event;
  logic woke;

  assign conv_event = internal_clock_mode_in ? conversion_done_in : word_bus.frame_end;
  assign woke = (state_reg == apcc_pkg::PS_DOWN) && (state_next == apcc_pkg::PS_ON) && auto_mode;

  // Counts conversions, not clocks, so the settle time follows the host's pace
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      discard_reg <= 2'h0;
    end else if (woke) begin
      discard_reg <= `APCC_WAKE_DISCARD;
    end else if (conv_event && discard_reg != 2'h0) begin
      discard_reg <= discard_reg - 2'h1;
    end
  end

  // ****************************************
  // Power and setup outputs
  // ****************************************
  logic core_next;
  logic bias_next;

  always_comb begin
    core_next = (state_reg == apcc_pkg::PS_ON) && !static_full && !static_partial;
    bias_next = 1'b0;
    if (static_full) begin
      bias_next = 1'b0;
    end else if (static_partial) begin
      bias_next = 1'b1;
    end else if (state_reg == apcc_pkg::PS_ON) begin
      bias_next = 1'b1;
    end else begin
      bias_next = auto_power_mode_in == `APCC_PM_STANDBY;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      core_power_on_out <= 1'b1;
      bias_power_on_out <= 1'b1;
      reference_power_on_out <= 1'b1;
      conversion_valid_out <= 1'b1;
    end else begin
      core_power_on_out <= core_next;
      bias_power_on_out <= bias_next;
      reference_power_on_out <= core_next || static_partial;
      conversion_valid_out <= core_next && (discard_reg == 2'h0);
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      reference_differential_out <= 1'b0;
      averaging_active_out <= 1'b0;
      conversions_per_result_out <= 6'h01;
      repeat_result_count_out <= 5'h00;
      setup_word_out <= `APCC_CFG_RESET;
    end else begin
      reference_differential_out <= cfg_reg[`APCC_REFERENCE_SOURCE_SELECT_BIT];
      averaging_active_out <= avg_on;
      conversions_per_result_out <=
        avg_conversions(avg_on, cfg_reg[`APCC_AVERAGING_COUNT_HI:`APCC_AVERAGING_COUNT_LO]);
      repeat_result_count_out <= repeat_mode_in ?
        repeat_results(cfg_reg[`APCC_REPEAT_RESULT_COUNT_HI:`APCC_REPEAT_RESULT_COUNT_LO]) : 5'h00;
      setup_word_out <= cfg_reg;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (rst_in);

  sequence s_ext_sleep;
    ext_auto && arm_reg && word_bus.frame_end && state_reg == apcc_pkg::PS_ON;
  endsequence

  sequence s_waking;
    woke ##1 1'b1;
  endsequence

  a_cfg_load_code: assert property (
    word_bus.word_valid && cfg_hit |=> cfg_reg == $past(word_bus.word[10:0]))
    else $error("setup word not loaded on matching code");

  a_cfg_ignore_other: assert property (
    word_bus.word_valid && !cfg_hit |=> $stable(cfg_reg))
    else $error("setup word changed on other code");

  a_static_full_off: assert property (
    static_full && $stable(static_mode) |=>
      !core_power_on_out && !bias_power_on_out && !reference_power_on_out)
    else $error("static full shutdown left circuits powered");

  a_static_partial_keep: assert property (
    static_partial && $stable(static_mode) |=>
      !core_power_on_out && bias_power_on_out && reference_power_on_out)
    else $error("static partial shutdown wrong supply set");

  a_ext_auto_down: assert property (
    s_ext_sleep |=> state_reg == apcc_pkg::PS_DOWN ##1 !core_power_on_out)
    else $error("no power down at armed frame end");

  a_ext_auto_wake: assert property (
    ext_auto && state_reg == apcc_pkg::PS_DOWN && word_bus.frame_start |=>
      state_reg == apcc_pkg::PS_ON)
    else $error("no wake at chip select fall");

  a_int_auto_down: assert property (
    int_auto && state_reg == apcc_pkg::PS_ON && conversion_done_in |=>
      state_reg == apcc_pkg::PS_DOWN)
    else $error("no power down after conversions");

  a_int_pin_wake: assert property (
    int_auto && state_reg == apcc_pkg::PS_DOWN && cnv_fall |=> state_reg == apcc_pkg::PS_ON)
    else $error("no wake on convert start fall");

  a_standby_bias: assert property (
    state_reg == apcc_pkg::PS_DOWN && auto_power_mode_in == `APCC_PM_STANDBY &&
      static_mode == 2'h0 |=> bias_power_on_out && !core_power_on_out)
    else $error("standby supply set wrong");

  a_wake_discard: assert property (
    s_waking |=> !conversion_valid_out)
    else $error("conversion valid right after wake");

  a_retain_down: assert property (
    sleep && !word_bus.word_valid |=> $stable(cfg_reg))
    else $error("setup lost at power down");

  a_avg_count: assert property (
    avg_on && cfg_reg[`APCC_AVERAGING_COUNT_HI:`APCC_AVERAGING_COUNT_LO] == 2'h3 && $stable(cfg_reg) |=>
      conversions_per_result_out == 6'h20)
    else $error("averaging count not thirty-two");

  a_avg_single: assert property (
    !cfg_reg[`APCC_AVERAGING_ENABLE_BIT] && $stable(cfg_reg) |=> conversions_per_result_out == 6'h01)
    else $error("more than one conversion with averaging off");

  a_repeat_count: assert property (
    repeat_mode_in && cfg_reg[`APCC_REPEAT_RESULT_COUNT_HI:`APCC_REPEAT_RESULT_COUNT_LO] == 2'h2 && $stable(cfg_reg) |=>
      repeat_result_count_out == 5'h0c)
    else $error("repeat code 10 not twelve results");
endmodule
`default_nettype wire

// File: verification/apcc_host_model.sv
// Host controller model driving the three-wire setup link
`timescale 1ns/1ns
`default_nettype none
module apcc_host_model (
  input wire logic clock_in,
  output logic chip_select_n_out,
  output logic serial_clock_out,
  output logic serial_data_out
);
  // ****************************************
  // Frame timing
  // ****************************************
  // Half period in system clocks; the receiver needs at least 1
  localparam int HALF = 4;
  initial begin
    chip_select_n_out = 1'b1;
    serial_clock_out = 1'b0;
    serial_data_out = 1'b0;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(negedge clock_in);
  endtask
  task automatic cs_fall();
    chip_select_n_out = 1'b0;
    wait_clk(HALF);
  endtask
  // Serial clock stands low outside frames
  task automatic shift(input apcc_pkg::apcc_word_t w);
    for (int i = 15; i >= 0; i--) begin
      serial_data_out = w[i];
      wait_clk(HALF);
      serial_clock_out = 1'b1;
      wait_clk(HALF);
      serial_clock_out = 1'b0;
    end
  endtask
  task automatic cs_rise();
    wait_clk(HALF);
    chip_select_n_out = 1'b1;
    // Released line flips so a stale bit never passes for data
    serial_data_out = ~serial_data_out;
    wait_clk(HALF);
  endtask
  task automatic send_word(input apcc_pkg::apcc_word_t w);
    cs_fall();
    shift(w);
    cs_rise();
  endtask
endmodule
`default_nettype wire

// File: verification/testbench.sv
// Self-checking bench for the power and setup-word control block
`timescale 1ns/1ns
`default_nettype none
module testbench;
  typedef struct packed {
    logic [15:0] word;
    logic im;
    logic rp;
    logic [10:0] setup;
    logic rd;
    logic av;
    logic [5:0] cpr;
    logic [4:0] rc;
    logic [2:0] pwr;
  } apcc_row_t;
  logic clock_in;
  logic rst_in;
  logic cs_n, sclk, sdata;
  logic cnv_n;
  logic im;
  logic rp;
  logic [1:0] apm;
  logic swc;
  logic done;
  logic core, bias, refp, valid, rdiff, avg;
  logic [5:0] cpr;
  logic [4:0] rc;
  logic [10:0] setup;
  int n_mismatch = 0;
  int check_count = 0;
  int cycles = 0;
  apcc_row_t rows [0:16];
  always #50 clock_in = ~clock_in;
  apcc_host_model host_u (
    .clock_in(clock_in),
    .chip_select_n_out(cs_n),
    .serial_clock_out(sclk),
    .serial_data_out(sdata)
  );
  apcc_top dut_u (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .chip_select_n_in(cs_n),
    .serial_clock_in(sclk),
    .serial_data_in(sdata),
    .convert_start_pin_n_in(cnv_n),
    .internal_clock_mode_in(im),
    .repeat_mode_in(rp),
    .auto_power_mode_in(apm),
    .software_convert_bit_in(swc),
    .conversion_done_in(done),
    .core_power_on_out(core),
    .bias_power_on_out(bias),
    .reference_power_on_out(refp),
    .conversion_valid_out(valid),
    .reference_differential_out(rdiff),
    .averaging_active_out(avg),
    .conversions_per_result_out(cpr),
    .repeat_result_count_out(rc),
    .setup_word_out(setup)
  );
  // ****************************************
  // Checking and closing
  // ****************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("mismatches %0d, checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Whole run needs about 3600 cycles
  always @(posedge clock_in) begin
    cycles++;
    if (cycles >= 20000) begin
      n_mismatch++;
      test_done();
    end
  end
  task automatic clk(input int n);
    repeat (n) @(negedge clock_in);
  endtask
  task automatic pulse_done();
    done = 1'b1;
    clk(1);
    done = 1'b0;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    clock_in = 1'b0;
    rst_in = 1'b1;
    cnv_n = 1'b1;
    im = 1'b0;
    rp = 1'b0;
    apm = 2'h0;
    swc = 1'b0;
    done = 1'b0;
    rows = '{
      '{16'h8400, 1'b0, 1'b0, 11'h400, 1'b1, 1'b0, 6'h01, 5'h00, 3'h7},
      '{16'h8200, 1'b1, 1'b0, 11'h200, 1'b0, 1'b1, 6'h04, 5'h00, 3'h7},
      '{16'h8280, 1'b1, 1'b0, 11'h280, 1'b0, 1'b1, 6'h08, 5'h00, 3'h7},
      '{16'h8300, 1'b1, 1'b0, 11'h300, 1'b0, 1'b1, 6'h10, 5'h00, 3'h7},
      '{16'h8380, 1'b1, 1'b0, 11'h380, 1'b0, 1'b1, 6'h20, 5'h00, 3'h7},
      '{16'h8380, 1'b0, 1'b0, 11'h380, 1'b0, 1'b0, 6'h01, 5'h00, 3'h7},
      '{16'h8180, 1'b1, 1'b0, 11'h180, 1'b0, 1'b0, 6'h01, 5'h00, 3'h7},
      '{16'h8000, 1'b0, 1'b1, 11'h000, 1'b0, 1'b0, 6'h01, 5'h04, 3'h7},
      '{16'h8020, 1'b0, 1'b1, 11'h020, 1'b0, 1'b0, 6'h01, 5'h08, 3'h7},
      '{16'h8040, 1'b0, 1'b1, 11'h040, 1'b0, 1'b0, 6'h01, 5'h0c, 3'h7},
      '{16'h8060, 1'b0, 1'b1, 11'h060, 1'b0, 1'b0, 6'h01, 5'h10, 3'h7},
      '{16'h8060, 1'b0, 1'b0, 11'h060, 1'b0, 1'b0, 6'h01, 5'h00, 3'h7},
      '{16'h9fff, 1'b0, 1'b1, 11'h060, 1'b0, 1'b0, 6'h01, 5'h10, 3'h7},
      '{16'h8008, 1'b0, 1'b0, 11'h008, 1'b0, 1'b0, 6'h01, 5'h00, 3'h0},
      '{16'h8010, 1'b0, 1'b0, 11'h010, 1'b0, 1'b0, 6'h01, 5'h00, 3'h3},
      '{16'h8018, 1'b0, 1'b0, 11'h018, 1'b0, 1'b0, 6'h01, 5'h00, 3'h7},
      '{16'h8000, 1'b0, 1'b0, 11'h000, 1'b0, 1'b0, 6'h01, 5'h00, 3'h7}
    };
    clk(5);
    rst_in = 1'b0;
    clk(3);
    check(setup, 16'h0000);
    check({core, bias, refp, valid}, 16'h000f);
    check(cpr, 16'h0001);
    check(rc, 16'h0000);
    foreach (rows[i]) begin
      im = rows[i].im;
      rp = rows[i].rp;
      host_u.send_word(rows[i].word);
      clk(8);
      check(setup, rows[i].setup);
      check(rdiff, rows[i].rd);
      check(avg, rows[i].av);
      check(cpr, rows[i].cpr);
      check(rc, rows[i].rc);
      check({core, bias, refp}, rows[i].pwr);
    end
    // External clock, automatic full off
    im = 1'b0;
    rp = 1'b0;
    apm = 2'h1;
    host_u.send_word(16'h8400);
    clk(8);
    check(core, 1'b1);
    host_u.send_word(16'h8400);
    clk(8);
    check({core, bias, refp}, 3'h0);
    check(setup, 16'h0400);
    host_u.cs_fall();
    clk(8);
    check(core, 1'b1);
    check(valid, 1'b0);
    host_u.shift(16'h0000);
    host_u.cs_rise();
    clk(8);
    check(core, 1'b0);
    // Standby keeps the bias generator only
    apm = 2'h2;
    host_u.send_word(16'h0000);
    host_u.send_word(16'h0000);
    clk(8);
    check({core, bias, refp}, 3'h2);
    host_u.cs_fall();
    clk(8);
    check(core, 1'b1);
    host_u.shift(16'h0000);
    host_u.cs_rise();
    apm = 2'h3;
    clk(8);
    check({core, bias, refp}, 3'h7);
    // Internal clock, automatic full off
    im = 1'b1;
    apm = 2'h1;
    clk(2);
    pulse_done();
    clk(4);
    check(core, 1'b0);
    cnv_n = 1'b0;
    clk(8);
    check(core, 1'b1);
    check(valid, 1'b0);
    cnv_n = 1'b1;
    clk(2);
    pulse_done();
    clk(4);
    check(core, 1'b0);
    swc = 1'b1;
    host_u.send_word(16'h0000);
    clk(8);
    check(core, 1'b1);
    swc = 1'b0;
    check(setup, 16'h0400);
    // Back to normal: two conversions pass before results count
    apm = 2'h0;
    clk(2);
    pulse_done();
    clk(4);
    check(valid, 1'b0);
    pulse_done();
    clk(4);
    check(valid, 1'b1);
    // Reset in mid-run clears the setup word and powers everything
    rst_in = 1'b1;
    clk(2);
    rst_in = 1'b0;
    clk(3);
    check(setup, 16'h0000);
    check({core, bias, refp, valid}, 16'h000f);
    test_done();
  end
endmodule
`default_nettype wire
